// [test/slhs_osc_model.sv]
// partner model: external oscillator with start-up delay and failure control
module slhs_osc_model #(
	parameter int STARTUP = 4
) (
	input  wire logic clk_sys,
	input  wire logic osc_run,
	input  wire logic crystal_ok,
	output logic      clock_present
);
	timeunit 1ns;
	timeprecision 100ps;

	int unsigned run_count = 0;

	// ----------------------------------------------------------------
	// start-up count: clock is absent while stopped or failed
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (!(osc_run && crystal_ok))
			run_count <= 0;
		else if (run_count < STARTUP)
			run_count <= run_count + 1;
	end

	// start-up is shorter than the bench reset hold
	assign clock_present = (run_count == STARTUP);

endmodule : slhs_osc_model

// [test/slhs_sequencer_test.sv]
// testbench: stop exit and limp-home sequencer against a behavioural model
module slhs_sequencer_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic                 clk_sys = 1'b0;
	logic                 reset, hsel, hwrite, hready, stop_exec, crystal_ok, clock_present_pin;
	logic [31:0]          haddr, hwdata, hrdata, rd;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	slhs_pkg::slhs_wake_t wake_pins;
	logic                 hreadyout, hresp, clock_monitor_active, clock_monitor_reset, osc_run, vco_run;
	logic                 bus_clock_pll_select_out, module_clock_slow_select_out, stop_active, pll_relock;
	logic                 limp_home_irq, cmr, mid_pll, mid_slow, relock, resp;
	int                   fail_count, total_checks, cycles, seed, n, t_exit, tick;
	int                   model_reg[4];
	int                   mask_of[3] = '{255, 3, 63};

	assign hready = hreadyout;
	always #4 clk_sys = ~clk_sys;

	slhs_sequencer DUT (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .stop_exec, .wake_pins, .clock_present_pin, .bus_clock_pll_select_out,
		.module_clock_slow_select_out, .clock_monitor_active, .clock_monitor_reset, .osc_run, .vco_run,
		.stop_active, .pll_relock, .limp_home_irq);
	slhs_osc_model OSC (.clk_sys, .osc_run, .crystal_ok, .clock_present(clock_present_pin));

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// bus and sequencer drivers
	// ----------------------------------------------------------------
	task wait_ready;
		@(posedge clk_sys);
		while (hready !== 1'b1)
			@(posedge clk_sys);
	endtask : wait_ready

	task bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] data);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr_en;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= data;
		wait_ready();
		rd = hrdata;
		resp = hresp;
	endtask : bus

	task wr(input logic [31:0] addr, input logic [31:0] data);
		bus(1'b1, addr, data);
		if (addr < 32'h0000_000c)
			model_reg[addr[3:2]] = data & mask_of[addr[3:2]];
	endtask : wr

	task rchk(input logic [31:0] addr, input logic [31:0] mask);
		bus(1'b0, addr, 32'h0000_0000);
		chk(rd & mask, (addr < 32'h0000_0010) ? model_reg[addr[3:2]] & mask : 32'h0000_0000);
		chk(resp, 1'b0);
	endtask : rchk

	task go_stop;
		stop_exec <= 1'b1;
		@(posedge clk_sys);
		cmr = clock_monitor_reset;
		stop_exec <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : go_stop

	task wake(input int b);
		n = 0;
		relock = 1'b0;
		wake_pins <= 5'(1 << b);
		@(posedge clk_sys);
		while (stop_active !== 1'b0) begin
			@(posedge clk_sys);
			n++;
			relock |= (pll_relock === 1'b1);
			if (n == 100) begin
				mid_pll = bus_clock_pll_select_out;
				mid_slow = module_clock_slow_select_out;
			end
		end
		wake_pins <= '0;
		t_exit = cycles;
	endtask : wake

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 98;
		{reset, hsel, hwrite, stop_exec, crystal_ok} = 5'b1_0001;
		{haddr, hwdata, htrans, hsize, wake_pins} = {64'h0, 2'b00, 3'b010, 5'h00};
		model_reg = '{32'h0000_00c6, 0, 0, 0};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++)
			rchk(32'(4 * i), 32'hffff_ffff);
		wr(32'h0000_0020, $random(seed));
		rchk(32'h0000_0020, 32'hffff_ffff);
		wr(slhs_pkg::OFF_CTRL, 32'h0000_0085);
		go_stop();
		chk(cmr, 1'b1);
		chk(stop_active, 1'b0);
		wr(slhs_pkg::OFF_CTRL, 32'h0000_00a4);
		for (int b = 0; b < 5; b++) begin
			go_stop();
			chk({cmr, clock_monitor_active, osc_run, stop_active}, 4'b0011);
			wake(b);
			chk(n < 4, 1'b1);
			rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		end
		for (int j = 0; j < 2; j++) begin
			wr(slhs_pkg::OFF_SLOW, (j == 0) ? $random(seed) : 0);
			wr(slhs_pkg::OFF_CTRL, 32'h0000_00a1);
			tick = (model_reg[2] == 0) ? 2 : 4 * model_reg[2];
			go_stop();
			wake(4);
			chk(n >= 15 * tick + 4 && n <= 16 * tick + 3, 1'b1);
		end
		wr(slhs_pkg::OFF_CTRL, 32'h0000_0083);
		go_stop();
		chk(osc_run, 1'b0);
		wake(1);
		chk(n >= 8190 && n <= 8200, 1'b1);
		rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		wr(slhs_pkg::OFF_CTRL, 32'h0000_0081);
		go_stop();
		wake(0);
		chk(n < 4, 1'b1);
		wr(slhs_pkg::OFF_CTRL, 32'h0000_00a2);
		wr(slhs_pkg::OFF_CLKSEL, 32'h0000_0003);
		go_stop();
		wake(2);
		chk({mid_pll, mid_slow}, 2'b10);
		chk(n >= 8190 && n <= 8200, 1'b1);
		rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		chk({bus_clock_pll_select_out, module_clock_slow_select_out, relock}, 3'b110);
		wr(slhs_pkg::OFF_CTRL, 32'h0000_00f2);
		go_stop();
		crystal_ok <= 1'b0;
		wake(3);
		chk(n >= 8190 && n <= 8200, 1'b1);
		model_reg[3] = 3;
		rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		chk({limp_home_irq, vco_run, bus_clock_pll_select_out, module_clock_slow_select_out, clock_monitor_active}, 5'b11101);
		wr(slhs_pkg::OFF_STATUS, 32'h0000_0002);
		model_reg[3] = 1;
		rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		chk(limp_home_irq, 1'b0);
		wr(slhs_pkg::OFF_CLKSEL, 32'h0000_0001);
		rchk(slhs_pkg::OFF_CLKSEL, 32'h0000_0003);
		chk({bus_clock_pll_select_out, module_clock_slow_select_out}, 2'b10);
		wr(slhs_pkg::OFF_CLKSEL, 32'h0000_0003);
		crystal_ok <= 1'b1;
		while (module_clock_slow_select_out !== 1'b1) begin
			@(posedge clk_sys);
			relock |= (pll_relock === 1'b1);
		end
		chk(cycles - t_exit >= 16370 && cycles - t_exit <= 16400, 1'b1);
		chk(relock, 1'b1);
		model_reg[3] = 2;
		rchk(slhs_pkg::OFF_STATUS, 32'h0000_0003);
		chk(limp_home_irq, 1'b1);
		print_verdict();
	end

endmodule : slhs_sequencer_test

// [verilog/slhs_pkg.sv]
// package: register map, field layouts, reset values and counts of the stop exit sequencer
package slhs_pkg;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CLKSEL = 8'h04;
	localparam logic [7:0] OFF_SLOW   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// ------------------------------------------------------------------
	// field layouts (bit 0 is the last member)
	// ------------------------------------------------------------------
	typedef struct packed {
		logic pll_on;
		logic auto_bw;
		logic pseudo_stop_enable;
		logic limp_home_irq_enable;
		logic forced_clock_monitor_enable;
		logic clock_monitor_enable;
		logic stop_exit_delay_enable;
		logic no_limp_home_select;
	} slhs_ctrl_t;

	typedef struct packed {
		logic bus_clock_pll_select;
		logic module_clock_slow_select;
	} slhs_clksel_t;

	typedef struct packed {
		logic ext_irq;
		logic nonmaskable_irq_pin;
		logic key_wake_j;
		logic key_wake_h;
		logic can_wake;
	} slhs_wake_t;

	// status word: bit 0 limp status, bit 1 change flag (write one to clear)
	localparam int STAT_LIMP_BIT = 0;
	localparam int STAT_FLAG_BIT = 1;
	localparam int SLOW_W        = 6;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam slhs_ctrl_t   CTRL_RST   = 8'hc6;
	localparam slhs_clksel_t CLKSEL_RST = 2'h0;
	localparam logic [SLOW_W-1:0] SLOW_RST = 6'h00;

	// ------------------------------------------------------------------
	// counts in divided slow clock cycles; 13-stage counter wraps at 8192
	// ------------------------------------------------------------------
	localparam logic [12:0] EXIT_DELAY_DIVIDED_SLOW_CLOCK = 13'h1000;
	localparam logic [12:0] SHORT_EXIT_DIVIDED_SLOW_CLOCK = 13'h0010;

	typedef enum {S_RUN, S_STOP, S_EXIT_WAIT} slhs_state_t;

endpackage : slhs_pkg

// [verilog/slhs_sequencer.sv]
// module: stop / pseudo-stop exit and limp-home sequencer with ahb-lite registers
// Function
// - in limp-home, check clock monitor when count reaches 4096, i.e. once every 8192 counts
// - clock found: leave limp-home, clear limp status, set change flag
// - on limp exit, pll and slow select outputs return to stored values
// - auto bandwidth and pll select both set: request pll relock on exit
// - square-wave clock, no delay: stop released at once, status never set
// - pseudo-stop enable set: stop keeps oscillator running
// - pseudo-stop exits on reset, irq pins, key wake-ups or can wake-up
// - delayed exit with limp allowed: limp-home, pll select high, slow low
// - delayed exit: after 4096 counts, clock present resumes on external clock
// - crystal failed: resume in limp-home with status and change flag set
// - limp allowed, no delay: pseudo-stop released without counter delay
// - recovering on limp clock restarts the vco halted in stop
// - no limp, monitor on: stop instruction causes clock-monitor reset
// - no limp, monitor off, delay: resume on external clock after 4096
// - no limp, monitor off, no delay: pseudo-stop resumes after 16
// - delay counts divided slow clock, so it scales with slow divider
// - delay bit one gives 4096 count wait; zero gives none, or 16 for pseudo-stop with no limp
// - limp allowed: monitor enables masked at stop, no monitor failure
// - limp interrupt raised when change flag set and irq enable set
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
module slhs_sequencer (
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               stop_exec,
	input  wire slhs_pkg::slhs_wake_t wake_pins,
	input  wire logic               clock_present_pin,
	output logic                    bus_clock_pll_select_out,
	output logic                    module_clock_slow_select_out,
	output logic                    clock_monitor_active,
	output logic                    clock_monitor_reset,
	output logic                    osc_run,
	output logic                    vco_run,
	output logic                    stop_active,
	output logic                    pll_relock,
	output logic                    limp_home_irq
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [5:0] pins_s;

	slhs_sync #(.W(6)) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.d       ({wake_pins, clock_present_pin}),
		.q       (pins_s)
	);

	wire wake_any = |pins_s[5:1];
	wire clk_ok   = pins_s[0];

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	slhs_pkg::slhs_ctrl_t        ctrl;
	slhs_pkg::slhs_clksel_t      clksel;
	logic [slhs_pkg::SLOW_W-1:0] slow;
	logic                        status_lh;
	logic                        flag;
	logic                        limp;
	logic                        pseudo_stop_enable_mode;
	slhs_pkg::slhs_state_t       state;
	slhs_pkg::slhs_state_t       next_state;
	logic                        next_limp;
	logic                        next_status;
	logic                        next_pseudo_stop_enable;
	logic                        set_flag;
	logic                        wake_start;
	logic                        cm_reset;
	logic                        relock;
	logic [12:0]                 cnt;
	logic [12:0]                 exit_target;
	logic [7:0]                  divcnt;

	// ------------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------------
	logic       dp_wr;
	logic       dp_rd;
	logic [7:0] dp_addr;

	wire ap_valid = hsel && hready && htrans[1] && (hsize == 3'h2);
	wire in_map   = haddr[31:4] == 28'h000_0000;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dp_wr   <= 1'b0;
			dp_rd   <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_wr   <= ap_valid && hwrite && in_map;
			dp_rd   <= ap_valid && !hwrite && in_map;
			dp_addr <= haddr[7:0];
		end
	end

	wire wr_ctrl   = dp_wr && (dp_addr == slhs_pkg::OFF_CTRL);
	wire wr_clksel = dp_wr && (dp_addr == slhs_pkg::OFF_CLKSEL);
	wire wr_slow   = dp_wr && (dp_addr == slhs_pkg::OFF_SLOW);
	wire wr_status = dp_wr && (dp_addr == slhs_pkg::OFF_STATUS);
	wire flag_clr  = wr_status && hwdata[slhs_pkg::STAT_FLAG_BIT];

	// pll select cannot be set with pll off; pll on cannot clear while selected
	wire new_bus_clock_pll_select  = hwdata[1] && ctrl.pll_on;
	wire new_pllon = hwdata[7] || clksel.bus_clock_pll_select;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl   <= slhs_pkg::CTRL_RST;
			clksel <= slhs_pkg::CLKSEL_RST;
			slow   <= slhs_pkg::SLOW_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= {new_pllon, hwdata[6:0]};
			if (wr_clksel)
				clksel <= {new_bus_clock_pll_select, hwdata[0]};
			if (wr_slow)
				slow <= hwdata[slhs_pkg::SLOW_W-1:0];
		end
	end

	wire [31:0] rd_mux =
		(dp_addr == slhs_pkg::OFF_CTRL)   ? {24'h00_0000, ctrl} :
		(dp_addr == slhs_pkg::OFF_CLKSEL) ? {30'h0000_0000, clksel} :
		(dp_addr == slhs_pkg::OFF_SLOW)   ? {26'h000_0000, slow} :
		(dp_addr == slhs_pkg::OFF_STATUS) ? {26'h000_0000, pseudo_stop_enable_mode, limp, stop_active, 1'b0, flag, status_lh} :
		32'h0000_0000;

	assign hrdata    = dp_rd ? rd_mux : 32'h0000_0000;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ------------------------------------------------------------------
	// divided slow clock tick and 13-stage counter
	// ------------------------------------------------------------------
	function automatic logic [7:0] divided_slow_clock_period(input logic [slhs_pkg::SLOW_W-1:0] s);
		divided_slow_clock_period = (s == '0) ? 8'h02 : {s, 2'b00};
	endfunction : divided_slow_clock_period

	wire        divided_slow_clock_tick = divcnt >= (divided_slow_clock_period(slow) - 8'h01);
	wire [12:0] next_cnt  = cnt + 13'h0001;
	wire        periodic  = divided_slow_clock_tick && (next_cnt == slhs_pkg::EXIT_DELAY_DIVIDED_SLOW_CLOCK);
	wire        exit_hit  = divided_slow_clock_tick && (next_cnt == exit_target);
	wire        cm_on     = ctrl.clock_monitor_enable || ctrl.forced_clock_monitor_enable;

	always_ff @(posedge clk_sys) begin
		if (reset || divided_slow_clock_tick)
			divcnt <= 8'h00;
		else
			divcnt <= divcnt + 8'h01;
	end

	always_ff @(posedge clk_sys) begin
		if (reset || wake_start)
			cnt <= 13'h0000;
		else if (divided_slow_clock_tick)
			cnt <= next_cnt;
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_limp   = limp;
		next_status = status_lh;
		next_pseudo_stop_enable   = pseudo_stop_enable_mode;
		set_flag    = 1'b0;
		wake_start  = 1'b0;
		cm_reset    = 1'b0;
		relock      = 1'b0;
		unique case (state)
			slhs_pkg::S_RUN: begin
				if (stop_exec) begin
					if (ctrl.no_limp_home_select && cm_on) begin
						cm_reset = 1'b1;
					end else begin
						next_state = slhs_pkg::S_STOP;
						next_pseudo_stop_enable  = ctrl.pseudo_stop_enable;
					end
				end else if (limp && periodic && clk_ok) begin
					next_limp   = 1'b0;
					next_status = 1'b0;
					set_flag    = 1'b1;
					relock      = ctrl.auto_bw && clksel.bus_clock_pll_select;
				end
			end
			slhs_pkg::S_STOP: begin
				if (wake_any) begin
					wake_start = 1'b1;
					if (!ctrl.no_limp_home_select && ctrl.stop_exit_delay_enable) begin
						next_limp  = 1'b1;
						next_state = slhs_pkg::S_EXIT_WAIT;
					end else if (!ctrl.no_limp_home_select) begin
						next_state = slhs_pkg::S_RUN;
						if (!clk_ok && !limp) begin
							next_limp   = 1'b1;
							next_status = 1'b1;
							set_flag    = 1'b1;
						end else if (clk_ok && limp) begin
							next_limp   = 1'b0;
							next_status = 1'b0;
							set_flag    = status_lh;
							relock      = ctrl.auto_bw && clksel.bus_clock_pll_select;
						end
					end else if (ctrl.stop_exit_delay_enable || pseudo_stop_enable_mode) begin
						next_state = slhs_pkg::S_EXIT_WAIT;
					end else begin
						next_state = slhs_pkg::S_RUN;
					end
				end
			end
			slhs_pkg::S_EXIT_WAIT: begin
				if (exit_hit) begin
					next_state = slhs_pkg::S_RUN;
					if (limp && clk_ok) begin
						next_limp   = 1'b0;
						next_status = 1'b0;
						set_flag    = status_lh;
						relock      = ctrl.auto_bw && clksel.bus_clock_pll_select;
					end else if (limp && !status_lh) begin
						next_status = 1'b1;
						set_flag    = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state       <= slhs_pkg::S_RUN;
			limp        <= 1'b0;
			status_lh   <= 1'b0;
			pseudo_stop_enable_mode   <= 1'b0;
			exit_target <= slhs_pkg::EXIT_DELAY_DIVIDED_SLOW_CLOCK;
		end else begin
			state     <= next_state;
			limp      <= next_limp;
			status_lh <= next_status;
			pseudo_stop_enable_mode <= next_pseudo_stop_enable;
			if (wake_start)
				exit_target <= ctrl.stop_exit_delay_enable ? slhs_pkg::EXIT_DELAY_DIVIDED_SLOW_CLOCK
				                                           : slhs_pkg::SHORT_EXIT_DIVIDED_SLOW_CLOCK;
		end
	end

	// set wins over the write-one clear
	always_ff @(posedge clk_sys) begin
		if (reset)
			flag <= 1'b0;
		else
			flag <= set_flag || (flag && !flag_clr);
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign bus_clock_pll_select_out     = limp || clksel.bus_clock_pll_select;
	assign module_clock_slow_select_out = !limp && clksel.module_clock_slow_select;
	assign clock_monitor_active         = limp || (cm_on && state != slhs_pkg::S_STOP);
	assign clock_monitor_reset          = cm_reset;
	assign osc_run                      = (state != slhs_pkg::S_STOP) || pseudo_stop_enable_mode;
	assign vco_run                      = (state != slhs_pkg::S_STOP) && (ctrl.pll_on || limp);
	assign stop_active                  = state != slhs_pkg::S_RUN;
	assign pll_relock                   = relock;
	assign limp_home_irq                = flag && ctrl.limp_home_irq_enable;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	irq_gate_a: assert property ($rose(flag) && ctrl.limp_home_irq_enable |-> limp_home_irq)
		else $error("limp irq missing");
	check_exit_a: assert property (state == slhs_pkg::S_RUN && limp && periodic && clk_ok && !stop_exec
		|=> !limp && !status_lh && flag)
		else $error("limp exit on check wrong");
	forced_sel_a: assert property (limp |-> bus_clock_pll_select_out && !module_clock_slow_select_out)
		else $error("limp selects not forced");
	restore_sel_a: assert property ($fell(limp) |-> bus_clock_pll_select_out == clksel.bus_clock_pll_select
		&& module_clock_slow_select_out == clksel.module_clock_slow_select)
		else $error("selects not restored");
	cm_reset_a: assert property (state == slhs_pkg::S_RUN && stop_exec && ctrl.no_limp_home_select && cm_on
		|-> clock_monitor_reset ##1 state == slhs_pkg::S_RUN)
		else $error("monitor reset missing");
	stop_mask_a: assert property (state == slhs_pkg::S_RUN && stop_exec && !ctrl.no_limp_home_select
		|-> !clock_monitor_reset ##1 state == slhs_pkg::S_STOP)
		else $error("stop not masked");
	fast_exit_a: assert property (state == slhs_pkg::S_STOP && wake_any && clk_ok && !limp
		&& !ctrl.no_limp_home_select && !ctrl.stop_exit_delay_enable |=> state == slhs_pkg::S_RUN && !status_lh)
		else $error("fast exit wrong");
	pseudo_osc_a: assert property (state == slhs_pkg::S_STOP && pseudo_stop_enable_mode |-> osc_run)
		else $error("oscillator stopped");
	relock_a: assert property (pll_relock |=> !limp)
		else $error("relock without exit");
	vco_limp_a: assert property (limp && state != slhs_pkg::S_STOP |-> vco_run)
		else $error("vco not running");
	delay_end_a: assert property (state == slhs_pkg::S_EXIT_WAIT && exit_hit |=> state == slhs_pkg::S_RUN)
		else $error("exit wait stuck");
	status_set_a: assert property (state == slhs_pkg::S_EXIT_WAIT && exit_hit && limp && !clk_ok && !status_lh
		|=> status_lh && flag && limp && state == slhs_pkg::S_RUN)
		else $error("limp resume flags wrong");
	short_wait_a: assert property (state == slhs_pkg::S_STOP && wake_any && ctrl.no_limp_home_select
		&& !ctrl.stop_exit_delay_enable && pseudo_stop_enable_mode |=> state == slhs_pkg::S_EXIT_WAIT && exit_target == slhs_pkg::SHORT_EXIT_DIVIDED_SLOW_CLOCK)
		else $error("short wait not set");
	limp_enter_a: assert property (state == slhs_pkg::S_STOP && wake_any && !ctrl.no_limp_home_select
		&& ctrl.stop_exit_delay_enable |=> limp && state == slhs_pkg::S_EXIT_WAIT)
		else $error("limp not entered on wake");
	nodelay_exit_a: assert property (state == slhs_pkg::S_STOP && wake_any && ctrl.no_limp_home_select
		&& !ctrl.stop_exit_delay_enable && !pseudo_stop_enable_mode |=> state == slhs_pkg::S_RUN)
		else $error("undelayed exit late");
	cnt_free_a: assert property (divided_slow_clock_tick && !wake_start |=> cnt == $past(next_cnt))
		else $error("counter not free running");
	flag_set_a: assert property (set_flag |=> flag)
		else $error("change flag not set");
	limp_status_a: assert property (status_lh |-> limp)
		else $error("status without limp");
	plain_stop_a: assert property (state == slhs_pkg::S_STOP && !pseudo_stop_enable_mode |-> !osc_run && !vco_run)
		else $error("clocks run in stop");

endmodule : slhs_sequencer

// [verilog/slhs_sync.sv]
// module: two flip-flop synchroniser for pin inputs
module slhs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : slhs_sync
